/* hdl/fmct_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fmct_host #(
  parameter int OSC_CYCLES = fmct_pkg::OSC_CYC,
  parameter int REF_CYCLES = fmct_pkg::REF_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Link to the modem.
  fmct_if.host link,
  // User side.
  input wire logic mode_spi,
  input wire logic osc_enable,
  input wire logic ref_enable,
  input wire logic pd_req,
  input wire logic tx_req,
  input wire logic tx_bit,
  output logic host_ready,
  output logic rx_bit,
  output logic carrier_present,
  output logic [7:0] spi_status,
  output logic status_valid
);

  logic [31:0] osc_reg;
  logic [31:0] ref_reg;
  logic [15:0] pow_reg;
  logic rts_n_reg;
  logic txd_reg;
  fmct_pkg::fmct_spi_state_e state_reg;
  logic [1:0] ph_reg;
  logic [2:0] bit_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] sent_reg;
  logic [7:0] gap_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic valid_reg;
  logic [7:0] ctl;

  // Power-up waits: oscillator, reference and power-down exit.
  always_ff @(posedge clk_sys) begin
    if (reset || !osc_enable) begin
      osc_reg <= 32'(OSC_CYCLES);
    end else if (osc_reg != 32'h0000_0000) begin
      osc_reg <= osc_reg - 32'h0000_0001;
    end
  end

  // Reference settling wait.
  always_ff @(posedge clk_sys) begin
    if (reset || !ref_enable) begin
      ref_reg <= 32'(REF_CYCLES);
    end else if (ref_reg != 32'h0000_0000) begin
      ref_reg <= ref_reg - 32'h0000_0001;
    end
  end

  // Power-down exit wait.
  always_ff @(posedge clk_sys) begin
    if (reset || pd_req) begin
      pow_reg <= 16'(fmct_pkg::POW_CYC);
    end else if (pow_reg != 16'h0000) begin
      pow_reg <= pow_reg - 16'h0001;
    end
  end

  assign host_ready = (osc_reg == 32'h0000_0000) && (ref_reg == 32'h0000_0000)
    && (pow_reg == 16'h0000) && !pd_req;
  assign link.power_down = pd_req;

  // UART pins: request-to-send low asks for the modulator.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rts_n_reg <= 1'b1;
      txd_reg <= 1'b1;
    end else begin
      rts_n_reg <= !(tx_req && host_ready && !mode_spi);
      txd_reg <= tx_bit;
    end
  end

  assign link.rts_n = rts_n_reg;
  assign link.txd = txd_reg;
  assign rx_bit = link.rxd;
  assign carrier_present = mode_spi ? spi_status[fmct_pkg::STS_CD_BIT] : link.carrier_detect_out;

  assign ctl = {tx_req && host_ready, 6'h00, tx_bit};

  // Serial-port master: one byte per frame, four clocks per bit, then a chip-select gap.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= fmct_pkg::FMCT_IDLE;
      ph_reg <= 2'h0;
      bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      sent_reg <= fmct_pkg::CTL_RESET;
      gap_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      unique case (state_reg)
        fmct_pkg::FMCT_IDLE: begin
          if (mode_spi && host_ready && (ctl != sent_reg || !link.irq_n)) begin
            state_reg <= fmct_pkg::FMCT_SHIFT;
            cs_n_reg <= 1'b0;
            tx_sh_reg <= ctl;
            sent_reg <= ctl;
            ph_reg <= 2'h0;
            bit_reg <= 3'h0;
          end
        end
        fmct_pkg::FMCT_SHIFT: begin
          ph_reg <= ph_reg + 2'h1;
          if (ph_reg == 2'h1) begin
            sclk_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[6:0], link.spi_sdo};
          end else if (ph_reg == 2'h3) begin
            sclk_reg <= 1'b0;
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              cs_n_reg <= 1'b1;
              valid_reg <= 1'b1;
              gap_reg <= 8'(fmct_pkg::CSGAP_CYC);
              state_reg <= fmct_pkg::FMCT_GAP;
            end
          end
        end
        fmct_pkg::FMCT_GAP: begin
          if (gap_reg == 8'h00) begin
            state_reg <= fmct_pkg::FMCT_IDLE;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= fmct_pkg::FMCT_IDLE;
        end
      endcase
    end
  end

  assign link.spi_cs_n = cs_n_reg;
  assign link.spi_sclk = sclk_reg;
  assign link.spi_sdi = tx_sh_reg[7];
  assign spi_status = rx_sh_reg;
  assign status_valid = valid_reg;

endmodule // fmct_host
`default_nettype wire

/* hdl/fmct_modem.sv */
// Functional notes
// - Carrier reaches first peak within 5 bit-times.
// - Carrier below receive amplitude within 3 bit-times.
// - Carrier fully zero within 6 bit-times.
// - Carrier detect rises within 6 bit-times.
// - Carrier detect falls within 3 ms.
// - After transmit, detect held off 2.1 ms.
// - Host waits 25 ms after oscillator enable.
// - Host waits 10 ms after reference enable.
// - Power-down exit takes 30 us.
// - Chip-select rising edges at least 3.06 us apart.
// - Half-duplex modem, slave or master role.
// - Transmit data passes over UART or serial-port control byte; receive data over UART only.
// - Serial output daisy-chains, with interrupt signalling.
// - Host drives request-to-send low to transmit.
// - Carrier detect high on valid receive carrier.
// - Mark 1200 Hz, space 2200 Hz tone.
`timescale 1ns/1ps
`default_nettype none
module fmct_modem #(
  parameter int BIT_CYCLES = fmct_pkg::BIT_CYC,
  parameter int CDON_CYCLES = fmct_pkg::CDON_CYC,
  parameter int CDOFF_CYCLES = fmct_pkg::CDOFF_FILT_CYC,
  parameter int CDHOLD_CYCLES = fmct_pkg::CDHOLD_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Link to the host.
  fmct_if.dev link,
  // Straps.
  input wire logic mode_spi,
  input wire logic role_master,
  // Receive path from the demodulator.
  input wire logic rx_carrier_valid,
  input wire logic rx_bit_in,
  // Transmit path to the converter.
  output logic [2:0] tx_amp,
  output logic [4:0] tx_phase,
  output logic tx_active
);

  localparam int UP_CYC = BIT_CYCLES / fmct_pkg::RAMP_UP_DIV;
  localparam int DN_CYC = BIT_CYCLES / fmct_pkg::RAMP_DN_DIV;

  logic rts_n_reg;
  logic [2:0] amp_reg;
  logic [31:0] step_reg;
  logic [23:0] phase_reg;
  logic [31:0] on_cnt_reg;
  logic [31:0] off_cnt_reg;
  logic [31:0] hold_reg;
  logic [15:0] wake_reg;
  logic cd_reg;
  logic cd_chg_reg;
  logic cd_q_reg;
  logic rxd_reg;
  logic cs_q_reg;
  logic sclk_q_reg;
  logic [7:0] shift_reg;
  logic [3:0] bits_reg;
  logic [7:0] ctl_reg;
  logic ready;
  logic tx_req;
  logic tx_bit;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic [7:0] status;

  // Request and data source: pin in UART mode, control byte in serial-port mode.
  assign ready = (wake_reg == 16'h0000) && !link.power_down;
  assign tx_req = ready && (mode_spi ? ctl_reg[fmct_pkg::CTL_RTS_BIT] : !rts_n_reg);
  assign tx_bit = mode_spi ? ctl_reg[fmct_pkg::CTL_TXD_BIT] : link.txd;
  assign tx_active = (amp_reg != fmct_pkg::AMP_ZERO);
  assign tx_amp = amp_reg;
  assign tx_phase = phase_reg[23:19];

  // The request pin is registered once so the ramp follows a clean clock edge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rts_n_reg <= 1'b1;
    end else begin
      rts_n_reg <= link.rts_n;
    end
  end

  // Wake-up timer: power-down exit counts 30 us before the modem acts.
  always_ff @(posedge clk_sys) begin
    if (reset || link.power_down) begin
      wake_reg <= 16'(fmct_pkg::POW_CYC);
    end else if (wake_reg != 16'h0000) begin
      wake_reg <= wake_reg - 16'h0001;
    end
  end

  // Envelope: full in under 2 bit-times, below receive level in 2, zero in 3.5.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      amp_reg <= fmct_pkg::AMP_ZERO;
      step_reg <= 32'h0000_0000;
    end else if (tx_req && amp_reg != fmct_pkg::AMP_FULL) begin
      if (step_reg >= 32'(UP_CYC - 1)) begin
        step_reg <= 32'h0000_0000;
        amp_reg <= amp_reg + 3'h1;
      end else begin
        step_reg <= step_reg + 32'h0000_0001;
      end
    end else if (!tx_req && amp_reg != fmct_pkg::AMP_ZERO) begin
      if (step_reg >= 32'(DN_CYC - 1)) begin
        step_reg <= 32'h0000_0000;
        amp_reg <= amp_reg - 3'h1;
      end else begin
        step_reg <= step_reg + 32'h0000_0001;
      end
    end else begin
      step_reg <= 32'h0000_0000;
    end
  end

  // Phase accumulator steps the 32-entry sine table at the tone rate.
  always_ff @(posedge clk_sys) begin
    if (reset || !tx_active && !tx_req) begin
      phase_reg <= 24'h00_0000;
    end else begin
      phase_reg <= phase_reg + (tx_bit ? fmct_pkg::MARK_INC : fmct_pkg::SPACE_INC);
    end
  end

  // Hold-off after turning from transmit to receive.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_reg <= 32'h0000_0000;
    end else if (tx_req) begin
      hold_reg <= 32'(CDHOLD_CYCLES);
    end else if (hold_reg != 32'h0000_0000) begin
      hold_reg <= hold_reg - 32'h0000_0001;
    end
  end

  // Presence filter on the receive carrier.
  always_ff @(posedge clk_sys) begin
    if (reset || !rx_carrier_valid) begin
      on_cnt_reg <= 32'h0000_0000;
    end else if (on_cnt_reg < 32'(CDON_CYCLES)) begin
      on_cnt_reg <= on_cnt_reg + 32'h0000_0001;
    end
  end

  // Absence filter on the receive carrier.
  always_ff @(posedge clk_sys) begin
    if (reset || rx_carrier_valid) begin
      off_cnt_reg <= 32'h0000_0000;
    end else if (off_cnt_reg < 32'(CDOFF_CYCLES)) begin
      off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
    end
  end

  // Carrier detect; never set while transmitting since the link is half-duplex.
  always_ff @(posedge clk_sys) begin
    if (reset || !ready || tx_req || tx_active) begin
      cd_reg <= 1'b0;
    end else if (!cd_reg && on_cnt_reg >= 32'(CDON_CYCLES) && hold_reg == 32'h0000_0000) begin
      cd_reg <= 1'b1;
    end else if (cd_reg && off_cnt_reg >= 32'(CDOFF_CYCLES)) begin
      cd_reg <= 1'b0;
    end
  end

  // Received data goes straight through in UART mode while a carrier is present.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxd_reg <= 1'b1;
    end else begin
      rxd_reg <= (!mode_spi && cd_reg) ? rx_bit_in : 1'b1;
    end
  end

  assign link.rxd = rxd_reg;
  assign link.carrier_detect_out = cd_reg;

  // Serial-port edge detection on synchronous link pins.
  assign cs_rise = !cs_q_reg && link.spi_cs_n;
  assign cs_fall = cs_q_reg && !link.spi_cs_n;
  assign sclk_rise = !sclk_q_reg && link.spi_sclk && !link.spi_cs_n;
  assign status = {cd_reg, tx_active, role_master, ready, 4'h0};

  // Edge history of chip select, serial clock and carrier detect.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_q_reg <= 1'b1;
      sclk_q_reg <= 1'b0;
      cd_q_reg <= 1'b0;
    end else begin
      cs_q_reg <= link.spi_cs_n;
      sclk_q_reg <= link.spi_sclk;
      cd_q_reg <= cd_reg;
    end
  end

  // Shift register: status out, control in; extra bits pass on for daisy-chains.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_reg <= 8'h00;
      bits_reg <= 4'h0;
    end else if (cs_fall) begin
      shift_reg <= status;
      bits_reg <= 4'h0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[6:0], link.spi_sdi};
      if (bits_reg != 4'(fmct_pkg::SPI_BITS)) begin
        bits_reg <= bits_reg + 4'h1;
      end
    end
  end

  assign link.spi_sdo = shift_reg[7];

  // The last eight bits shifted in become the control byte at chip-select release.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_reg <= fmct_pkg::CTL_RESET;
    end else if (mode_spi && cs_rise && bits_reg == 4'(fmct_pkg::SPI_BITS)) begin
      ctl_reg <= shift_reg;
    end
  end

  // Interrupt on any carrier detect change in serial-port mode; a finished frame clears it, a change wins.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cd_chg_reg <= 1'b0;
    end else if (mode_spi && (cd_reg != cd_q_reg)) begin
      cd_chg_reg <= 1'b1;
    end else if (cs_rise) begin
      cd_chg_reg <= 1'b0;
    end
  end

  assign link.irq_n = !cd_chg_reg;

endmodule // fmct_modem
`default_nettype wire

/* shared/fmct_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Link between the host controller and the modem.
interface fmct_if;
  logic rts_n;
  logic txd;
  logic rxd;
  logic carrier_detect_out;
  logic power_down;
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_sdi;
  logic spi_sdo;
  logic irq_n;

  modport dev (
    input rts_n, txd, power_down, spi_cs_n, spi_sclk, spi_sdi,
    output rxd, carrier_detect_out, spi_sdo, irq_n
  );

  modport host (
    output rts_n, txd, power_down, spi_cs_n, spi_sclk, spi_sdi,
    input rxd, carrier_detect_out, spi_sdo, irq_n
  );
endinterface
`default_nettype wire

/* shared/fmct_pkg.sv */
// Shared constants for the modem carrier timing block and its host end.
`default_nettype none
package fmct_pkg;

  // Device clock and line rate.
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_HZ = 1200;
  localparam int BIT_CYC = CLK_HZ / BAUD_HZ;

  // Carrier timing limits in bit-times.
  localparam int CSTART_BT = 5;
  localparam int CSTOP_BT = 3;
  localparam int CDECAY_BT = 6;
  localparam int CDON_BT = 6;

  // Carrier detect timing in microseconds.
  localparam int CDOFF_US = 3000;
  localparam int CDHOLD_US = 2100;

  // Power-up waits of the host, in microseconds and nanoseconds.
  localparam int OSC_US = 25000;
  localparam int REF_US = 10000;
  localparam int POW_US = 30;
  localparam int CSGAP_NS = 3060;

  // Cycle counts; least times round up, longest times round down.
  localparam int CDOFF_CYC = (CDOFF_US * (CLK_HZ / 1000000));
  localparam int CDHOLD_CYC = (CDHOLD_US * (CLK_HZ / 1000000));
  localparam int OSC_CYC = (OSC_US * (CLK_HZ / 1000000));
  localparam int REF_CYC = (REF_US * (CLK_HZ / 1000000));
  localparam int POW_CYC = (POW_US * (CLK_HZ / 1000000));
  localparam int CSGAP_CYC = (CSGAP_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Carrier detect filters: on after 4 bit-times, off with one bit-time of margin.
  localparam int CDON_CYC = BIT_CYC * 4;
  localparam int CDOFF_FILT_CYC = CDOFF_CYC - BIT_CYC;

  // Envelope of the transmit carrier.
  localparam int AMP_W = 3;
  localparam logic [2:0] AMP_FULL = 3'h7;
  localparam logic [2:0] AMP_RX = 3'h4;
  localparam logic [2:0] AMP_ZERO = 3'h0;
  localparam int RAMP_UP_DIV = 4;
  localparam int RAMP_DN_DIV = 2;

  // Tone generator: 24-bit phase accumulator; one wrap walks all 32 table steps once.
  localparam int PHASE_W = 24;
  localparam int TBL_W = 5;
  localparam logic [23:0] MARK_INC =
    24'((64'd1200 * 64'h0100_0000) / 64'd25000000);
  localparam logic [23:0] SPACE_INC =
    24'((64'd2200 * 64'h0100_0000) / 64'd25000000);

  // Serial port frame and control byte layout.
  localparam int SPI_BITS = 8;
  localparam int CTL_RTS_BIT = 7;
  localparam int CTL_TXD_BIT = 0;
  localparam int STS_CD_BIT = 7;
  localparam int STS_TX_BIT = 6;
  localparam int STS_MASTER_BIT = 5;
  localparam int STS_READY_BIT = 4;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Host serial port states.
  typedef enum logic [1:0] {FMCT_IDLE, FMCT_SHIFT, FMCT_GAP} fmct_spi_state_e;

endpackage
`default_nettype wire

/* tb/fmct_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Timing checks on the modem link, the envelope and the carrier input.
module fmct_assertions #(
  parameter int BIT_CYCLES = 40,
  parameter int CDOFF_CYCLES = 100,
  parameter int CDHOLD_CYCLES = 120
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Watched signals.
  input wire logic rts_n,
  input wire logic carrier_detect_out,
  input wire logic spi_cs_n,
  input wire logic power_down,
  input wire logic rx_carrier_valid,
  input wire logic [2:0] tx_amp
);
  localparam int T_START = 5 * BIT_CYCLES;
  localparam int T_STOP = 3 * BIT_CYCLES;
  localparam int T_DECAY = 6 * BIT_CYCLES;
  localparam int T_CDON = 6 * BIT_CYCLES;
  localparam int T_IDLE = CDHOLD_CYCLES + T_CDON + 800;
  int vcnt;
  int icnt;
  int idle;
  int qcnt;
  int gcnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Run length of a present carrier.
  always_ff @(posedge clk_sys)
    if (reset || !rx_carrier_valid) vcnt <= 0;
    else if (vcnt < 100000) vcnt <= vcnt + 1;
  // Run length of a missing carrier.
  always_ff @(posedge clk_sys)
    if (reset || rx_carrier_valid) icnt <= 0;
    else if (icnt < 100000) icnt <= icnt + 1;
  // Quiet time with no request, no envelope and no power-down.
  always_ff @(posedge clk_sys)
    if (reset || power_down || !rts_n || tx_amp != 3'h0) idle <= 0;
    else if (idle < 100000) idle <= idle + 1;
  // Time since the request was last low.
  always_ff @(posedge clk_sys)
    if (reset) qcnt <= 100000;
    else if (!rts_n) qcnt <= 0;
    else if (qcnt < 100000) qcnt <= qcnt + 1;
  // Time since the last rising edge of chip-select.
  always_ff @(posedge clk_sys)
    if (reset) gcnt <= 100000;
    else if ($rose(spi_cs_n)) gcnt <= 0;
    else if (gcnt < 100000) gcnt <= gcnt + 1;
  chk_start_peak: assert property (disable iff (reset || power_down)
    $fell(rts_n) |-> ##[1:T_START] (tx_amp == 3'h7 || rts_n))
    else $error("carrier peak late");
  chk_stop_level: assert property ($rose(rts_n) |-> ##[1:T_STOP] (tx_amp < 3'h4 || !rts_n))
    else $error("carrier stop late");
  chk_decay_zero: assert property ($rose(rts_n) |-> ##[1:T_DECAY] (tx_amp == 3'h0 || !rts_n))
    else $error("carrier decay late");
  chk_detect_on: assert property (disable iff (reset || power_down)
    vcnt >= T_CDON && idle >= T_IDLE |-> carrier_detect_out)
    else $error("carrier detect late");
  chk_detect_off: assert property (icnt > CDOFF_CYCLES + 3 |-> !carrier_detect_out)
    else $error("carrier detect stuck");
  chk_hold_off: assert property (rts_n && qcnt >= 1 && qcnt < CDHOLD_CYCLES
    |-> !carrier_detect_out) else $error("detect inside hold-off");
  chk_half_duplex: assert property (tx_amp != 3'h0 |-> !carrier_detect_out)
    else $error("detect while sending");
  chk_ramp_sync: assert property ($fell(rts_n) && tx_amp == 3'h0 |-> ##1 tx_amp == 3'h0)
    else $error("ramp before request seen");
  chk_select_gap: assert property ($rose(spi_cs_n) |-> gcnt >= fmct_pkg::CSGAP_CYC - 1)
    else $error("chip-select rises too close");
endmodule // fmct_assertions
`default_nettype wire

/* tb/fmct_modem_carrier_timing_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 5000) begin @(negedge clk_sys); n++; end \
  if (n >= 5000) begin err_count++; $display("mismatch wait expected done seen timeout"); end end
// Host and modem face each other; the bench drives both user sides.
module fmct_modem_carrier_timing_test;
  localparam int BIT = 40;
  localparam int CDON = 160;
  localparam int CDOFF = 100;
  localparam int CDHOLD = 120;
  logic clk_sys, reset, mode_spi, role_master, rx_carrier_valid, rx_bit_in;
  logic osc_enable, ref_enable, pd_req, tx_req, tx_bit;
  logic host_ready, rx_bit, carrier_present, status_valid, tx_active;
  logic [7:0] spi_status;
  logic [2:0] tx_amp;
  logic [4:0] tx_phase;
  logic [31:0] seed = 32'h0000_3a85;
  logic [7:0] exp_q[$];
  logic [7:0] ev;
  logic tone_hold, tone;
  int err_count, compares, n, k;
  fmct_if link();
  fmct_modem #(.BIT_CYCLES(BIT), .CDON_CYCLES(CDON), .CDOFF_CYCLES(CDOFF),
    .CDHOLD_CYCLES(CDHOLD)) fmct_modem_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
    .mode_spi(mode_spi), .role_master(role_master), .rx_carrier_valid(rx_carrier_valid),
    .rx_bit_in(rx_bit_in), .tx_amp(tx_amp), .tx_phase(tx_phase), .tx_active(tx_active));
  fmct_host #(.OSC_CYCLES(50), .REF_CYCLES(30)) fmct_host_inst (.clk_sys(clk_sys),
    .reset(reset), .link(link), .mode_spi(mode_spi), .osc_enable(osc_enable),
    .ref_enable(ref_enable), .pd_req(pd_req), .tx_req(tx_req), .tx_bit(tx_bit),
    .host_ready(host_ready), .rx_bit(rx_bit), .carrier_present(carrier_present),
    .spi_status(spi_status), .status_valid(status_valid));
  fmct_assertions #(.BIT_CYCLES(BIT), .CDOFF_CYCLES(CDOFF), .CDHOLD_CYCLES(CDHOLD))
    fmct_assertions_inst (.clk_sys(clk_sys), .reset(reset), .rts_n(link.rts_n),
    .carrier_detect_out(link.carrier_detect_out), .spi_cs_n(link.spi_cs_n),
    .power_down(link.power_down), .rx_carrier_valid(rx_carrier_valid), .tx_amp(tx_amp));
  // Next value of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request a burst, release it at the given level and time the envelope.
  task automatic tx_round(input logic [2:0] lvl);
    tx_req = 1'b1;
    `WAITC(link.rts_n === 1'b0)
    `WAITC(tx_amp === lvl)
    `CHECK("start", 1'b1, n <= 5 * BIT)
    `CHECK("active", 1'b1, tx_active)
    tx_req = 1'b0;
    `WAITC(link.rts_n === 1'b1)
    `WAITC(tx_amp < 3'h4)
    `CHECK("stop", 1'b1, n <= 3 * BIT)
    k = n;
    `WAITC(tx_amp === 3'h0)
    `CHECK("decay", 1'b1, k + n <= 6 * BIT)
    $display("test burst done");
  endtask
  // Hold one tone at full level and time one step of the table index.
  task automatic tone_check(input logic mark, input int per);
    tone = mark;
    tone_hold = 1'b1;
    tx_req = 1'b1;
    `WAITC(tx_amp === 3'h7)
    k = int'(tx_phase);
    `WAITC(tx_phase !== k[4:0])
    k = int'(tx_phase);
    `WAITC(tx_phase !== k[4:0])
    `CHECK("tone", 1'b1, n >= per - 1 && n <= per + 1)
    tx_req = 1'b0;
    tone_hold = 1'b0;
    `WAITC(tx_amp === 3'h0)
    $display("test tone done");
  endtask
  // The clock runs at 25 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Random data bits reach both ends at the falling edge.
  always @(negedge clk_sys) begin
    seed <= xs(seed);
    rx_bit_in <= seed[0];
    tx_bit <= (tone_hold ? tone : seed[1]) & !mode_spi;
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("mismatch watchdog expected finish seen timeout");
    results;
  end
  // Main sequence.
  initial begin
    {mode_spi, role_master, rx_carrier_valid, pd_req, tx_req, tone_hold, tone} = 7'h00;
    {osc_enable, ref_enable} = 2'h3;
    err_count = 0;
    compares = 0;
    reset = 1'b1;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    `WAITC(host_ready === 1'b1)
    `CHECK("wake", 1'b1, n >= 749)
    `CHECK("idle_rts", 1'b1, link.rts_n)
    $display("test wake done");
    tx_round(3'h7);
    tx_round(3'h3);
    tone_check(1'b1, fmct_pkg::CLK_HZ / (1200 * 32));
    tone_check(1'b0, fmct_pkg::CLK_HZ / (2200 * 32));
    repeat (1200) @(negedge clk_sys);
    rx_carrier_valid = 1'b1;
    `WAITC(carrier_present === 1'b1)
    `CHECK("cd_on", 1'b1, n <= 6 * BIT)
    repeat (2) @(negedge clk_sys);
    for (k = 0; k < 298; k++) begin
      `CHECK("rxd", rx_bit_in, rx_bit)
      @(negedge clk_sys);
    end
    rx_carrier_valid = 1'b0;
    `WAITC(carrier_present === 1'b0)
    `CHECK("cd_off", 1'b1, n <= CDOFF + BIT)
    $display("test detect done");
    rx_carrier_valid = 1'b1;
    `WAITC(carrier_present === 1'b1)
    tx_req = 1'b1;
    `WAITC(link.rts_n === 1'b0)
    repeat (10) @(negedge clk_sys);
    `CHECK("duplex", 1'b0, carrier_present)
    tx_req = 1'b0;
    `WAITC(link.rts_n === 1'b1)
    `WAITC(carrier_present === 1'b1)
    `CHECK("holdoff", 1'b1, n >= CDHOLD && n < 5000)
    rx_carrier_valid = 1'b0;
    `WAITC(carrier_present === 1'b0)
    $display("test hold-off done");
    pd_req = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHECK("pd_ready", 1'b0, host_ready)
    pd_req = 1'b0;
    `WAITC(host_ready === 1'b1)
    `CHECK("pd_exit", 1'b1, n >= 749)
    osc_enable = 1'b0;
    @(negedge clk_sys);
    osc_enable = 1'b1;
    `WAITC(host_ready === 1'b1)
    `CHECK("osc_wait", 1'b1, n >= 49)
    ref_enable = 1'b0;
    @(negedge clk_sys);
    ref_enable = 1'b1;
    `WAITC(host_ready === 1'b1)
    `CHECK("ref_wait", 1'b1, n >= 29)
    $display("test power-down done");
    role_master = seed[2];
    mode_spi = 1'b1;
    repeat (200) @(negedge clk_sys);
    tx_req = 1'b1;
    exp_q.push_back({2'b00, role_master, 1'b1, 4'h0});
    `WAITC(status_valid === 1'b1)
    ev = exp_q.pop_front();
    `CHECK("status_idle", ev, spi_status)
    `WAITC(tx_amp === 3'h7)
    `CHECK("spi_start", 1'b1, n <= 5 * BIT)
    tx_req = 1'b0;
    exp_q.push_back({2'b01, role_master, 1'b1, 4'h0});
    `WAITC(status_valid === 1'b1)
    ev = exp_q.pop_front();
    `CHECK("status_tx", ev, spi_status)
    `WAITC(tx_amp === 3'h0)
    `CHECK("spi_decay", 1'b1, n <= 6 * BIT)
    rx_carrier_valid = 1'b1;
    exp_q.push_back({2'b10, role_master, 1'b1, 4'h0});
    `WAITC(status_valid === 1'b1)
    ev = exp_q.pop_front();
    `CHECK("status_cd", ev, spi_status)
    `CHECK("cd_spi", 1'b1, carrier_present)
    $display("test serial port done");
    results;
  end
endmodule // fmct_modem_carrier_timing_test
`default_nettype wire
